// File: shared/mdg_pkg.sv
// Constants, types and decode limits for the memory decode glue
package mdg_pkg;

  // ----------------------------------------
  // Socket space options
  // ----------------------------------------
  typedef enum logic [1:0] {
    MDG_SP_NONE = 2'h0,  // Socket disabled
    MDG_SP_DATA = 2'h1,  // Data space only
    MDG_SP_PROG = 2'h2,  // Program space only
    MDG_SP_BOTH = 2'h3   // Same address in both spaces
  } mdg_space_t;

  // ----------------------------------------
  // Select outputs, all active low but the external pass
  // ----------------------------------------
  typedef struct packed {
    logic rom_cs_n;   // Monitor ROM chip select
    logic rom_oe_n;   // Monitor ROM output enable
    logic sram_cs_n;  // User SRAM chip select
    logic sram_oe_n;  // User SRAM output enable
    logic sram_we_n;  // User SRAM write enable
    logic io_cs_n;    // On-board mapped I/O select
    logic ext_access; // Cycle passed to external resources
  } mdg_sel_t;

  // Nothing selected, nothing driving the shared lines
  localparam mdg_sel_t MDG_SEL_IDLE = 7'h7E;

  // ----------------------------------------
  // Decode limits on the three top address lines
  // ----------------------------------------
  localparam logic [2:0] MDG_ROM_TOP_END = 3'h2;  // ROM below 4000h
  localparam logic [2:0] MDG_SRAM_TOP_LO = 3'h2;  // SRAM from 4000h
  localparam logic [2:0] MDG_SRAM_TOP_8K = 3'h2;  // 8k SRAM up to 5FFFh
  localparam logic [2:0] MDG_SRAM_TOP_32K = 3'h5; // 32k SRAM up to BFFFh

  // ----------------------------------------
  // Full-address limits
  // ----------------------------------------
  localparam logic [15:0] MDG_PROG_ONBOARD_MAX = 16'hBDFF; // Last on-board fetch
  localparam logic [15:0] MDG_IO_BASE = 16'hFFE0;          // Mapped I/O window

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] MDG_SYNC_HIGH = 2'h3;  // Strobes idle high
  localparam logic [7:0] MDG_BYTE_ZERO = 8'h00; // Cleared address byte
  localparam logic [5:0] MDG_CFG_RESET = 6'h00; // Configuration before sampling
  localparam logic MDG_MODEM_ON = 1'h1;         // Modem lines asserted

endpackage : mdg_pkg

// File: shared/mdg_dec_if.sv
// Carrier between the glue top and its address decoder
`timescale 1ns/100ps
interface mdg_dec_if;
  import mdg_pkg::*;

  logic [15:0] addr;     // Full bus address
  logic rd_n;            // Data read strobe
  logic wr_n;            // Data write strobe
  logic fetch_n;         // Program fetch strobe
  mdg_space_t rom_space; // Monitor ROM socket space
  mdg_space_t sram_space;// User SRAM socket space
  logic overlap;         // Overlapped memory mode
  logic sram_32k;        // 32k SRAM installed
  mdg_sel_t sel;         // Decoded selects

  // Decoder side
  modport dec (
    input addr, rd_n, wr_n, fetch_n, rom_space, sram_space, overlap, sram_32k,
    output sel
  );

  // Top side
  modport user (
    output addr, rd_n, wr_n, fetch_n, rom_space, sram_space, overlap, sram_32k,
    input sel
  );
endinterface : mdg_dec_if

// File: hdl/mdg_decode.sv
// Combinational address and space decoder for the memory sockets
`timescale 1ns/100ps
module mdg_decode
  import mdg_pkg::*;
(
  // Decoder carrier
  mdg_dec_if.dec bus
);

  // ----------------------------------------
  // Space helpers
  // ----------------------------------------
  // True when the socket answers in data space
  function automatic logic in_data(input mdg_space_t sp);
    in_data = (sp == MDG_SP_DATA) || (sp == MDG_SP_BOTH);
  endfunction

  // True when the socket answers in program space
  function automatic logic in_prog(input mdg_space_t sp);
    in_prog = (sp == MDG_SP_PROG) || (sp == MDG_SP_BOTH);
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Working terms of the decode
  logic [2:0] top;
  logic data_act;
  logic prog_act;
  logic sram_win;
  logic io_hit;
  logic rom_hit;
  logic sram_prog;
  logic sram_data;

  // Select terms from strobes, address and configuration
  always_comb begin
    top = bus.addr[15:13];
    data_act = !bus.rd_n || !bus.wr_n;
    prog_act = !bus.fetch_n;
    // Window follows the installed SRAM size
    if (bus.sram_32k) begin
      sram_win = (top >= MDG_SRAM_TOP_LO) && (top <= MDG_SRAM_TOP_32K);
    end else begin
      sram_win = (top >= MDG_SRAM_TOP_LO) && (top <= MDG_SRAM_TOP_8K);
    end
    // Mapped I/O wins over memory in data space
    io_hit = data_act && (bus.addr >= MDG_IO_BASE);
    // ROM in the low window, in whichever space it is placed
    rom_hit = (top < MDG_ROM_TOP_END) &&
              ((prog_act && in_prog(bus.rom_space)) ||
               (data_act && !io_hit && in_data(bus.rom_space)));
    // SRAM fetches end at the last on-board program address
    sram_prog = prog_act && in_prog(bus.sram_space) && sram_win &&
                (bus.addr <= MDG_PROG_ONBOARD_MAX);
    // Overlap also opens the SRAM to data space
    sram_data = data_act && !io_hit && sram_win &&
                (in_data(bus.sram_space) || bus.overlap);
    bus.sel = MDG_SEL_IDLE;
    bus.sel.rom_cs_n = !rom_hit;
    // ROM drives only on a read or fetch strobe
    bus.sel.rom_oe_n = !(rom_hit && (prog_act || !bus.rd_n));
    bus.sel.sram_cs_n = !(sram_prog || sram_data);
    bus.sel.sram_oe_n = !((sram_prog || sram_data) && (prog_act || !bus.rd_n));
    // Data writes reach SRAM, also when mapped to both spaces
    bus.sel.sram_we_n = !(sram_data && !bus.wr_n);
    bus.sel.io_cs_n = !io_hit;
    // Anything unclaimed on board goes to the outside
    bus.sel.ext_access = (data_act || prog_act) && !io_hit && !rom_hit &&
                         !sram_prog && !sram_data;
  end

endmodule // mdg_decode

// File: hdl/mdg_glue_top.sv
// Memory decode glue: address latch, decoder and modem line hold
//
// Overview of operation
// - Shared port carries low address, then data
// - Latch low address on address strobe fall
// - Join latched low with high address byte
// - Decode the three top lines; full address for I/O and fetch limit
// - Select field only by the active strobe
// - Program and data spaces share sixteen lines
// - Sockets map to data, program or both
// - Data writes reach sockets mapped to both
// - Decode follows 8k or 32k SRAM size
// - Ignore DTR, RTS; hold CTS, DSR asserted
// - Monitor ROM serves fetches below 4000h
// - Fetches above BDFFh go to external resources
// - Data FFE0h to FFFFh selects mapped I/O
// - Overlap adds SRAM data access 4000h-BFFFh with 32k SRAM, 4000h-5FFFh with 8k
`timescale 1ns/100ps
module mdg_glue_top
  import mdg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Controller bus pins
  input wire logic ale_in,
  input wire logic [7:0] low_addr_data_port_in,
  input wire logic [7:0] high_addr_port_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic program_fetch_strobe_n_in,
  // Static mapping configuration
  input wire logic [1:0] rom_space_in,
  input wire logic [1:0] sram_space_in,
  input wire logic overlap_mode_in,
  input wire logic sram_32k_in,
  // Incoming modem control, unused
  input wire logic dtr_in,
  input wire logic rts_in,
  // Memory address and selects
  output logic [15:0] addr_out,
  output logic rom_cs_n_out,
  output logic rom_oe_n_out,
  output logic sram_cs_n_out,
  output logic sram_oe_n_out,
  output logic sram_we_n_out,
  output logic io_cs_n_out,
  output logic ext_access_out,
  // Outgoing modem control
  output logic cts_out,
  output logic dsr_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] ale_sync;   // Address strobe synchroniser
    logic [1:0] rd_sync;    // Read strobe synchroniser
    logic [1:0] wr_sync;    // Write strobe synchroniser
    logic [1:0] fetch_sync; // Fetch strobe synchroniser
    logic [7:0] lo_m;       // Low port, first stage
    logic [7:0] lo_s;       // Low port, second stage
    logic [7:0] hi_m;       // High port, first stage
    logic [7:0] hi_s;       // High port, second stage
    logic [5:0] cfg_m;      // Configuration, first stage
    logic [5:0] cfg_s;      // Configuration, second stage
    logic ale_prev;         // Address strobe one cycle back
    logic [7:0] addr_lo;    // Latched low address byte
    logic [7:0] addr_hi;    // Registered high address byte
    mdg_sel_t sel;          // Registered selects
    logic modem_on;         // CTS and DSR level
  } mdg_state_t;

  mdg_state_t s;      // Current state
  mdg_state_t next_s; // Next state
  logic ale_fall;     // Address strobe falling edge

  // Decoder carrier
  mdg_dec_if dec_bus ();

  // ----------------------------------------
  // Decoder hookup
  // ----------------------------------------
  // Decoder sees the latched address and synchronised strobes
  assign dec_bus.addr = {s.addr_hi, s.addr_lo};
  assign dec_bus.rd_n = s.rd_sync[1];
  assign dec_bus.wr_n = s.wr_sync[1];
  assign dec_bus.fetch_n = s.fetch_sync[1];
  assign dec_bus.rom_space = mdg_space_t'(s.cfg_s[5:4]);
  assign dec_bus.sram_space = mdg_space_t'(s.cfg_s[3:2]);
  assign dec_bus.overlap = s.cfg_s[1];
  assign dec_bus.sram_32k = s.cfg_s[0];

  // Address decoder
  mdg_decode u_decode (
    .bus(dec_bus)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Falling edge seen on the second synchroniser stage only
  assign ale_fall = s.ale_prev && !s.ale_sync[1];

  // Synchronise pins, latch the address, register the selects
  always_comb begin
    next_s = s;
    next_s.ale_sync = {s.ale_sync[0], ale_in};
    next_s.rd_sync = {s.rd_sync[0], rd_n_in};
    next_s.wr_sync = {s.wr_sync[0], wr_n_in};
    next_s.fetch_sync = {s.fetch_sync[0], program_fetch_strobe_n_in};
    next_s.lo_m = low_addr_data_port_in;
    next_s.lo_s = s.lo_m;
    next_s.hi_m = high_addr_port_in;
    next_s.hi_s = s.hi_m;
    next_s.cfg_m = {rom_space_in, sram_space_in, overlap_mode_in, sram_32k_in};
    next_s.cfg_s = s.cfg_m;
    next_s.ale_prev = s.ale_sync[1];
    // Low byte is taken while the port still holds the address
    if (ale_fall) begin
      next_s.addr_lo = s.lo_s;
    end
    next_s.addr_hi = s.hi_s;
    next_s.sel = dec_bus.sel;
    // Modem lines stay asserted, incoming ones unread
    next_s.modem_on = MDG_MODEM_ON;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Single register stage for all state
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s.ale_sync <= 2'h0;
      s.rd_sync <= MDG_SYNC_HIGH;
      s.wr_sync <= MDG_SYNC_HIGH;
      s.fetch_sync <= MDG_SYNC_HIGH;
      s.lo_m <= MDG_BYTE_ZERO;
      s.lo_s <= MDG_BYTE_ZERO;
      s.hi_m <= MDG_BYTE_ZERO;
      s.hi_s <= MDG_BYTE_ZERO;
      s.cfg_m <= MDG_CFG_RESET;
      s.cfg_s <= MDG_CFG_RESET;
      s.ale_prev <= 1'h0;
      s.addr_lo <= MDG_BYTE_ZERO;
      s.addr_hi <= MDG_BYTE_ZERO;
      s.sel <= MDG_SEL_IDLE;
      s.modem_on <= MDG_MODEM_ON;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign addr_out = {s.addr_hi, s.addr_lo};
  assign rom_cs_n_out = s.sel.rom_cs_n;
  assign rom_oe_n_out = s.sel.rom_oe_n;
  assign sram_cs_n_out = s.sel.sram_cs_n;
  assign sram_oe_n_out = s.sel.sram_oe_n;
  assign sram_we_n_out = s.sel.sram_we_n;
  assign io_cs_n_out = s.sel.io_cs_n;
  assign ext_access_out = s.sel.ext_access;
  assign cts_out = s.modem_on;
  assign dsr_out = s.modem_on;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  latch_capture_a: assert property (ale_fall |=> addr_out[7:0] == $past(s.lo_s))
    else $error("low address not latched on strobe fall");
  latch_hold_a: assert property (!ale_fall |=> $stable(addr_out[7:0]))
    else $error("low address changed without strobe fall");
  // High byte is checked only once its three-stage path has left reset
  high_join_a: assert property ($past(resetn_in, 3) |-> addr_out[15:8] == $past(high_addr_port_in, 3))
    else $error("high address byte not joined");
  idle_quiet_a: assert property ((s.rd_sync[1] && s.wr_sync[1] && s.fetch_sync[1])
                                 |=> s.sel == MDG_SEL_IDLE)
    else $error("select active with no strobe");
  io_window_a: assert property ((!s.rd_sync[1] && addr_out >= MDG_IO_BASE)
                                |=> !io_cs_n_out && sram_cs_n_out && rom_cs_n_out)
    else $error("I/O window not selected");
  rom_fetch_a: assert property ((!s.fetch_sync[1] && addr_out < 16'h4000 && s.cfg_s[5])
                                |=> !rom_cs_n_out && !rom_oe_n_out)
    else $error("monitor ROM missed a fetch");
  rom_read_a: assert property (!rom_oe_n_out |-> $past(!s.rd_sync[1] || !s.fetch_sync[1]))
    else $error("ROM enabled without a read strobe");
  write_both_a: assert property ((!s.wr_sync[1] && s.cfg_s[3:2] == MDG_SP_BOTH && s.cfg_s[0]
                                  && addr_out >= 16'h4000 && addr_out < 16'hC000)
                                 |=> !sram_we_n_out)
    else $error("data write missed SRAM in both spaces");
  ext_pass_a: assert property ((!s.fetch_sync[1] && addr_out > MDG_PROG_ONBOARD_MAX)
                               |=> ext_access_out && sram_cs_n_out)
    else $error("high fetch not passed outside");
  overlap_a: assert property ((!s.rd_sync[1] && s.cfg_s[1] && s.cfg_s[0]
                               && addr_out >= 16'h4000 && addr_out < 16'hC000)
                              |=> !sram_cs_n_out && !sram_oe_n_out)
    else $error("overlap read missed SRAM");
  sram_8k_a: assert property ((!s.cfg_s[0] && addr_out[15:13] != MDG_SRAM_TOP_8K)
                              |=> sram_cs_n_out)
    else $error("8k SRAM selected outside its window");
  modem_held_a: assert property (cts_out && dsr_out)
    else $error("modem lines not asserted");
  sram_we_a: assert property (!sram_we_n_out |-> $past(!s.wr_sync[1]))
    else $error("SRAM write enable without a write strobe");

  // Main scenarios reached by the bench
  rom_fetch_c: cover property (!rom_cs_n_out && !rom_oe_n_out);
  overlap_read_c: cover property (!sram_oe_n_out && s.cfg_s[1]);
  sram_write_c: cover property (!sram_we_n_out);
  io_access_c: cover property (!io_cs_n_out);
  ext_pass_c: cover property (ext_access_out);

endmodule // mdg_glue_top

// File: tb/mdg_cpu_model.sv
// Controller bus model that drives the glue's multiplexed bus pins
`timescale 1ns/100ps
module mdg_cpu_model (
  // Clock
  input wire logic clk_in,
  // Bus pins toward the glue
  output logic ale_out,
  output logic [7:0] lo_out,
  output logic [7:0] hi_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic fetch_n_out
);
  // Idle bus at time zero, strobes high
  initial begin
    ale_out = 1'h0;
    lo_out = 8'hFF;
    hi_out = 8'hFF;
    rd_n_out = 1'h1;
    wr_n_out = 1'h1;
    fetch_n_out = 1'h1;
  end

  // Address phase then one strobe low; kind 0 fetch, 1 read, 2 write
  task automatic start(input logic [15:0] a, input logic [1:0] k);
    @(posedge clk_in);
    ale_out <= 1'h1;
    lo_out <= a[7:0];
    hi_out <= a[15:8];
    repeat (2) @(posedge clk_in);
    ale_out <= 1'h0;
    // Address stays on the shared port around the strobe fall
    repeat (3) @(posedge clk_in);
    // Write data or a released port, never the old address
    lo_out <= (k == 2'h2) ? ~a[7:0] : ~lo_out;
    rd_n_out <= (k != 2'h1);
    wr_n_out <= (k != 2'h2);
    fetch_n_out <= (k != 2'h0);
  endtask

  // End of cycle: strobes released, port floats to a new pattern
  task automatic stop();
    @(posedge clk_in);
    rd_n_out <= 1'h1;
    wr_n_out <= 1'h1;
    fetch_n_out <= 1'h1;
    lo_out <= ~lo_out;
  endtask
endmodule // mdg_cpu_model

// File: tb/tb.sv
// Self-checking bench for the memory decode glue
`timescale 1ns/100ps
module tb;
  import mdg_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk_in, resetn_in, dtr, rts, ovl, s32; // Bench-driven inputs
  logic [1:0] rom_sp, sram_sp; // Socket space codes
  logic ale, rd_n, wr_n, fetch_n; // Model strobes
  logic [7:0] lo, hi; // Model address pins
  logic [15:0] addr; // Memory address out
  wire [6:0] sel; // Selects in package order, driven by the glue
  logic cts, dsr; // Modem outputs
  int error_cnt, comparisons;

  // Clock, 10 ns period
  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  mdg_cpu_model m (.clk_in(ref_clk_in), .ale_out(ale), .lo_out(lo), .hi_out(hi),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .fetch_n_out(fetch_n));

  mdg_glue_top DUT (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ale_in(ale),
    .low_addr_data_port_in(lo), .high_addr_port_in(hi), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .program_fetch_strobe_n_in(fetch_n), .rom_space_in(rom_sp), .sram_space_in(sram_sp),
    .overlap_mode_in(ovl), .sram_32k_in(s32), .dtr_in(dtr), .rts_in(rts), .addr_out(addr),
    .rom_cs_n_out(sel[6]), .rom_oe_n_out(sel[5]), .sram_cs_n_out(sel[4]),
    .sram_oe_n_out(sel[3]), .sram_we_n_out(sel[2]), .io_cs_n_out(sel[1]),
    .ext_access_out(sel[0]), .cts_out(cts), .dsr_out(dsr));

  // ----------------------------------------
  // Compare helpers
  // ----------------------------------------
  task automatic chk_sel(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t selects %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Expected selects from address, access kind and mapping
  function automatic logic [6:0] exp_sel(input logic [15:0] a, input logic [1:0] k);
    logic i, r, s;
    i = (k != 2'h0) && (a >= 16'hFFE0);
    r = !i && (a < 16'h4000) && ((k == 2'h0) ? rom_sp[1] : rom_sp[0]);
    s = !i && (a >= 16'h4000) && (a <= (s32 ? 16'hBFFF : 16'h5FFF)) &&
        ((k == 2'h0) ? (sram_sp[1] && (a <= 16'hBDFF)) : (sram_sp[0] || ovl));
    return {~r, ~(r && (k != 2'h2)), ~s, ~(s && (k != 2'h2)), ~(s && (k == 2'h2)), ~i, !(r || s || i)};
  endfunction

  // Mapping change, then let it pass the input syncs
  task automatic cfg(input logic [1:0] r, input logic [1:0] s, input logic o, input logic z);
    @(posedge ref_clk_in);
    rom_sp <= r;
    sram_sp <= s;
    ovl <= o;
    s32 <= z;
    repeat (3) @(posedge ref_clk_in);
  endtask

  // One bus cycle: check address and selects mid-strobe, then idle after
  task automatic run(input logic [15:0] a, input logic [1:0] k);
    m.start(a, k);
    repeat (5) @(posedge ref_clk_in);
    #1;
    chk_word(addr, a);
    chk_sel(sel, exp_sel(a, k));
    m.stop();
    repeat (5) @(posedge ref_clk_in);
    #1;
    chk_sel(sel, MDG_SEL_IDLE);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Monitor ROM under every socket space code
  task automatic t_rom();
    for (int sp = 0; sp < 4; sp++) begin
      cfg(sp[1:0], MDG_SP_DATA, 1'h0, 1'h1);
      run(16'h0000, 2'h0);
      run(16'h3FFF, 2'h1);
      run(16'h4000, 2'h0);
      run(16'h2000, 2'h2);
    end
  endtask

  // SRAM window edges for both sizes
  task automatic t_sram();
    cfg(MDG_SP_NONE, MDG_SP_DATA, 1'h0, 1'h0);
    run(16'h5FFF, 2'h1);
    run(16'h6000, 2'h2);
    cfg(MDG_SP_NONE, MDG_SP_DATA, 1'h0, 1'h1);
    run(16'hBFFF, 2'h1);
    run(16'hC000, 2'h1);
    cfg(MDG_SP_NONE, MDG_SP_NONE, 1'h0, 1'h1);
    run(16'h4000, 2'h1);
  endtask

  // Fetch limit and writes into shared program memory
  task automatic t_fetch();
    cfg(MDG_SP_PROG, MDG_SP_BOTH, 1'h0, 1'h1);
    run(16'hBDFF, 2'h0);
    run(16'hBE00, 2'h0);
    run(16'h4000, 2'h2);
    run(16'h8123, 2'h1);
  endtask

  // Mapped I/O window in data space only
  task automatic t_io();
    run(16'hFFE0, 2'h1);
    run(16'hFFFF, 2'h2);
    run(16'hFFDF, 2'h1);
    run(16'hFFE0, 2'h0);
  endtask

  // Overlapped mode adds SRAM to data space
  task automatic t_ovl();
    cfg(MDG_SP_PROG, MDG_SP_PROG, 1'h0, 1'h1);
    run(16'h4000, 2'h1);
    cfg(MDG_SP_PROG, MDG_SP_PROG, 1'h1, 1'h1);
    run(16'h4000, 2'h1);
    run(16'hBFFF, 2'h2);
    run(16'hC000, 2'h1);
  endtask

  // Modem inputs toggle, outputs stay asserted
  task automatic t_modem();
    @(posedge ref_clk_in);
    dtr <= 1'h1;
    rts <= 1'h1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk_word({14'h0000, cts, dsr}, 16'h0003);
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    comparisons = 0;
    resetn_in = 1'h0;
    dtr = 1'h0;
    rts = 1'h0;
    ovl = 1'h0;
    s32 = 1'h1;
    rom_sp = MDG_SP_PROG;
    sram_sp = MDG_SP_DATA;
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk_word(addr, 16'h0000);
    chk_sel(sel, MDG_SEL_IDLE);
    chk_word({14'h0000, cts, dsr}, 16'h0003);
    @(posedge ref_clk_in);
    resetn_in <= 1'h1;
    repeat (2) @(posedge ref_clk_in);
    t_rom();
    t_sram();
    t_fetch();
    t_io();
    t_ovl();
    t_modem();
    give_verdict();
  end
endmodule // tb
